// ---- src/dld_params.svh ----
// Register map, descriptor layout and field positions of the descriptor list DMA
`ifndef DLD_PARAMS_SVH
`define DLD_PARAMS_SVH
`define DLD_REG_CTRL     8'h00
`define DLD_REG_TX_BASE  8'h04
`define DLD_REG_RX_BASE  8'h08
`define DLD_REG_STATUS   8'h0C
`define DLD_REG_CUR      8'h10
`define DLD_CTRL_RX_EN   0
`define DLD_CTRL_TX_EN   1
`define DLD_CTRL_CHAIN   2
`define DLD_ST_RX_NODESC 8
`define DLD_ST_TX_NODESC 9
`define DLD_ST_STATE_MSB 1
`define DLD_ST_CHAN      4
`define DLD_DW_CTRL      2'h0
`define DLD_DW_SIZE      2'h1
`define DLD_DW_BUF       2'h2
`define DLD_DW_NEXT      2'h3
`define DLD_OWN_BIT      31
`define DLD_FS_BIT       30
`define DLD_LS_BIT       29
`define DLD_SIZE_MSB     10
`define DLD_SIZE_LSB     2
`define DLD_ENTRY_W      33
`define DLD_LAST_BIT     32
`endif

// ---- src/dld_pkg.sv ----
// Types shared by the descriptor list DMA modules
package dld_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DESC  = 2'h1,
        ST_XFER  = 2'h2,
        ST_WBACK = 2'h3
    } dld_state_t;
    typedef enum logic {
        CH_RX = 1'h0,
        CH_TX = 1'h1
    } dld_chan_t;
endpackage

// ---- src/dld_stream_if.sv ----
// Valid/ready carrier between the DMA engine and its transmit buffer
`timescale 1ns/1ps
`include "dld_params.svh"
interface dld_stream_if;
    logic                    in_valid;
    logic                    in_ready;
    logic [`DLD_ENTRY_W-1:0] in_data;
    logic                    out_valid;
    logic                    out_ready;
    logic [`DLD_ENTRY_W-1:0] out_data;
    modport src (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
endinterface

// ---- src/dld_buf2.sv ----
// Two-entry buffer; head entry drives the output straight from a register
`timescale 1ns/1ps
`include "dld_params.svh"
module dld_buf2 (
    input wire logic     clk,
    input wire logic     rst_n,
    dld_stream_if.fifo   bif
);
    logic [`DLD_ENTRY_W-1:0] head_ff;
    logic [`DLD_ENTRY_W-1:0] tail_ff;
    logic [1:0]              cnt_ff;
    logic                    valid_ff;
    logic                    push;
    logic                    pop;

    assign bif.in_ready  = (cnt_ff != 2'h2);
    assign bif.out_valid = valid_ff;
    assign bif.out_data  = head_ff;
    assign push = bif.in_valid & bif.in_ready;
    assign pop  = valid_ff & bif.out_ready;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff   <= 2'h0;
            valid_ff <= 1'b0;
        end else begin
            if (push & ~pop) begin
                cnt_ff <= 2'(cnt_ff + 2'h1);
            end else if (pop & ~push) begin
                cnt_ff <= 2'(cnt_ff - 2'h1);
            end
            valid_ff <= (cnt_ff == 2'h2) | push | (cnt_ff == 2'h1 & ~pop);
        end
    end

    // Data regs need no reset; valid_ff guards them
    always_ff @(posedge clk) begin
        if (cnt_ff == 2'h2) begin
            if (pop) begin
                head_ff <= tail_ff;
            end
        end else if (push) begin
            if (cnt_ff == 2'h0 || pop) begin
                head_ff <= bif.in_data;
            end else begin
                tail_ff <= bif.in_data;
            end
        end
    end
endmodule

// ---- src/dld_desc_dma.sv ----
// Descriptor list DMA engine: APB registers, bus-master port, MAC rx/tx streams
`timescale 1ns/1ps
`include "dld_params.svh"
module dld_desc_dma (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_valid,
    input  wire logic        rx_last,
    output logic             rx_ready,
    output logic      [31:0] tx_data,
    output logic             tx_valid,
    output logic             tx_last,
    input  wire logic        tx_ready
);
    dld_pkg::dld_state_t state_ff;
    dld_pkg::dld_chan_t  chan_ff;
    logic        rx_en_ff, tx_en_ff, chain_en_ff;
    logic        rx_nodesc_ff, tx_nodesc_ff;
    logic [31:0] rx_base_ff, tx_base_ff, rx_cur_ff, tx_cur_ff;
    logic [31:0] desc0_ff, buf_ff, next_ff;
    logic [1:0]  widx_ff;
    logic [8:0]  words_ff, cnt_ff;
    logic        first_ff, ls_ff, last_seen_ff, drop_ff;
    logic        rx_ready_ff, push_ff;
    logic [`DLD_ENTRY_W-1:0] push_data_ff;
    logic        mem_req_ff, mem_we_ff;
    logic [31:0] mem_addr_ff, mem_wdata_ff, prdata_ff;
    logic        pready_ff, pslverr_ff;
    logic [31:0] rd_mux;
    logic [31:0] cur_addr;
    logic [8:0]  cnt_inc;
    logic        apb_setup, apb_wr, mem_done, rx_take, at_end, desc_empty, wb_done;

    dld_stream_if bif ();
    dld_buf2 dld_buf2_i (
        .clk   (clk),
        .rst_n (rst_n),
        .bif   (bif.fifo)
    );
    assign bif.in_valid  = push_ff;
    assign bif.in_data   = push_data_ff;
    assign bif.out_ready = tx_ready;
    assign tx_valid  = bif.out_valid;
    assign tx_data   = bif.out_data[`DLD_LAST_BIT-1:0];
    assign tx_last   = bif.out_data[`DLD_LAST_BIT];
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign mem_req   = mem_req_ff;
    assign mem_we    = mem_we_ff;
    assign mem_addr  = mem_addr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign rx_ready  = rx_ready_ff;

    // Pointers are physical; no translation
    function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [8:0] idx);
        word_addr = base + {21'h0_0000, idx, 2'h0};
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `DLD_REG_CTRL) || (a == `DLD_REG_TX_BASE) || (a == `DLD_REG_RX_BASE)
               || (a == `DLD_REG_STATUS) || (a == `DLD_REG_CUR);
    endfunction

    assign apb_setup  = psel & ~penable;
    assign apb_wr     = psel & penable & pready_ff & pwrite;
    assign mem_done   = mem_req_ff & mem_ack;
    assign rx_take    = rx_valid & rx_ready_ff;
    assign cnt_inc    = 9'(cnt_ff + 9'h001);
    assign at_end     = (cnt_inc == words_ff);
    assign cur_addr   = (chan_ff == dld_pkg::CH_RX) ? rx_cur_ff : tx_cur_ff;
    assign desc_empty = (state_ff == dld_pkg::ST_DESC) & mem_done & (widx_ff == `DLD_DW_CTRL)
                      & ~mem_rdata[`DLD_OWN_BIT];
    assign wb_done    = (state_ff == dld_pkg::ST_WBACK) & mem_done;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `DLD_REG_CTRL: begin
                rd_mux[`DLD_CTRL_RX_EN] = rx_en_ff;
                rd_mux[`DLD_CTRL_TX_EN] = tx_en_ff;
                rd_mux[`DLD_CTRL_CHAIN] = chain_en_ff;
            end
            `DLD_REG_TX_BASE: rd_mux = tx_base_ff;
            `DLD_REG_RX_BASE: rd_mux = rx_base_ff;
            `DLD_REG_STATUS: begin
                rd_mux[`DLD_ST_STATE_MSB:0] = state_ff;
                rd_mux[`DLD_ST_CHAN]        = chan_ff;
                rd_mux[`DLD_ST_RX_NODESC] = rx_nodesc_ff;
                rd_mux[`DLD_ST_TX_NODESC] = tx_nodesc_ff;
            end
            `DLD_REG_CUR: rd_mux = cur_addr;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait-free access cycle; read data latched at setup
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup & ~reg_hit(paddr);
            if (apb_setup & ~pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_en_ff    <= 1'b0;
            tx_en_ff    <= 1'b0;
            chain_en_ff <= 1'b0;
            rx_base_ff  <= 32'h0000_0000;
            tx_base_ff  <= 32'h0000_0000;
        end else if (apb_wr) begin
            if (paddr == `DLD_REG_CTRL) begin
                rx_en_ff    <= pwdata[`DLD_CTRL_RX_EN];
                tx_en_ff    <= pwdata[`DLD_CTRL_TX_EN];
                chain_en_ff <= pwdata[`DLD_CTRL_CHAIN];
            end
            if (paddr == `DLD_REG_TX_BASE) begin
                tx_base_ff <= pwdata;
            end
            if (paddr == `DLD_REG_RX_BASE) begin
                rx_base_ff <= pwdata;
            end
        end
    end

    // Set wins over a write-one clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_nodesc_ff <= 1'b0;
            tx_nodesc_ff <= 1'b0;
        end else begin
            rx_nodesc_ff <= (desc_empty & chan_ff == dld_pkg::CH_RX) | (rx_nodesc_ff
                & ~(apb_wr & paddr == `DLD_REG_STATUS & pwdata[`DLD_ST_RX_NODESC]));
            tx_nodesc_ff <= (desc_empty & chan_ff == dld_pkg::CH_TX) | (tx_nodesc_ff
                & ~(apb_wr & paddr == `DLD_REG_STATUS & pwdata[`DLD_ST_TX_NODESC]));
        end
    end

    // Software base write beats a link advance in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_cur_ff <= 32'h0000_0000;
            tx_cur_ff <= 32'h0000_0000;
        end else begin
            if (apb_wr & paddr == `DLD_REG_RX_BASE) begin
                rx_cur_ff <= pwdata;
            end else if (wb_done & chan_ff == dld_pkg::CH_RX) begin
                rx_cur_ff <= next_ff;
            end
            if (apb_wr & paddr == `DLD_REG_TX_BASE) begin
                tx_cur_ff <= pwdata;
            end else if (wb_done & chan_ff == dld_pkg::CH_TX) begin
                tx_cur_ff <= next_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff     <= dld_pkg::ST_IDLE;
            chan_ff      <= dld_pkg::CH_RX;
            widx_ff      <= `DLD_DW_CTRL;
            desc0_ff     <= 32'h0000_0000;
            buf_ff       <= 32'h0000_0000;
            next_ff      <= 32'h0000_0000;
            words_ff     <= 9'h000;
            cnt_ff       <= 9'h000;
            first_ff     <= 1'b1;
            ls_ff        <= 1'b0;
            last_seen_ff <= 1'b0;
            drop_ff      <= 1'b0;
            rx_ready_ff  <= 1'b0;
            push_ff      <= 1'b0;
            push_data_ff <= 33'h0_0000_0000;
            mem_req_ff   <= 1'b0;
            mem_we_ff    <= 1'b0;
            mem_addr_ff  <= 32'h0000_0000;
            mem_wdata_ff <= 32'h0000_0000;
        end else begin
            push_ff <= 1'b0;
            unique case (state_ff)
                dld_pkg::ST_IDLE: begin
                    widx_ff <= `DLD_DW_CTRL;
                    // Receive first: the MAC FIFO cannot wait forever
                    if (rx_en_ff & rx_valid & ~rx_nodesc_ff) begin
                        chan_ff     <= dld_pkg::CH_RX;
                        state_ff    <= dld_pkg::ST_DESC;
                        mem_req_ff  <= 1'b1;
                        mem_we_ff   <= 1'b0;
                        mem_addr_ff <= rx_cur_ff;
                    end else if (tx_en_ff & ~tx_nodesc_ff) begin
                        chan_ff     <= dld_pkg::CH_TX;
                        state_ff    <= dld_pkg::ST_DESC;
                        mem_req_ff  <= 1'b1;
                        mem_we_ff   <= 1'b0;
                        mem_addr_ff <= tx_cur_ff;
                    end
                end
                dld_pkg::ST_DESC: begin
                    if (mem_done) begin
                        widx_ff     <= 2'(widx_ff + 2'h1);
                        mem_addr_ff <= word_addr(cur_addr, {7'h00, 2'(widx_ff + 2'h1)});
                        case (widx_ff)
                            `DLD_DW_CTRL: begin
                                desc0_ff <= mem_rdata;
                                if (!mem_rdata[`DLD_OWN_BIT]) begin
                                    mem_req_ff <= 1'b0;
                                    state_ff   <= dld_pkg::ST_IDLE;
                                end
                            end
                            `DLD_DW_SIZE: words_ff <= mem_rdata[`DLD_SIZE_MSB:`DLD_SIZE_LSB];
                            `DLD_DW_BUF:  buf_ff   <= mem_rdata;
                            `DLD_DW_NEXT: begin
                                next_ff      <= mem_rdata;
                                mem_req_ff   <= 1'b0;
                                cnt_ff       <= 9'h000;
                                drop_ff      <= 1'b0;
                                last_seen_ff <= 1'b0;
                                state_ff     <= dld_pkg::ST_XFER;
                                rx_ready_ff  <= (chan_ff == dld_pkg::CH_RX) & (words_ff != 9'h000);
                            end
                        endcase
                    end
                end
                dld_pkg::ST_XFER: begin
                    if (words_ff == 9'h000) begin
                        // Empty buffer: frame begins in the next one
                        state_ff <= dld_pkg::ST_WBACK;
                        ls_ff    <= (chan_ff == dld_pkg::CH_TX) & desc0_ff[`DLD_LS_BIT];
                    end else if (chan_ff == dld_pkg::CH_RX) begin
                        if (rx_take & drop_ff) begin
                            if (rx_last) begin
                                rx_ready_ff <= 1'b0;
                                ls_ff       <= 1'b1;
                                state_ff    <= dld_pkg::ST_WBACK;
                            end
                        end else if (rx_take) begin
                            rx_ready_ff  <= 1'b0;
                            mem_req_ff   <= 1'b1;
                            mem_we_ff    <= 1'b1;
                            mem_addr_ff  <= word_addr(buf_ff, cnt_ff);
                            mem_wdata_ff <= rx_data;
                            last_seen_ff <= rx_last;
                        end else if (mem_done) begin
                            mem_req_ff <= 1'b0;
                            cnt_ff     <= cnt_inc;
                            if (last_seen_ff) begin
                                ls_ff    <= 1'b1;
                                state_ff <= dld_pkg::ST_WBACK;
                            end else if (at_end & chain_en_ff) begin
                                ls_ff    <= 1'b0;
                                state_ff <= dld_pkg::ST_WBACK;
                            end else begin
                                // No chaining: rest of the frame is thrown away
                                drop_ff     <= at_end;
                                rx_ready_ff <= 1'b1;
                            end
                        end
                    end else begin
                        if (mem_done) begin
                            push_ff      <= 1'b1;
                            push_data_ff <= {desc0_ff[`DLD_LS_BIT] & at_end, mem_rdata};
                            mem_req_ff   <= 1'b0;
                            cnt_ff       <= cnt_inc;
                            if (at_end) begin
                                ls_ff    <= desc0_ff[`DLD_LS_BIT];
                                state_ff <= dld_pkg::ST_WBACK;
                            end
                        end else if (!mem_req_ff & !push_ff & bif.in_ready) begin
                            mem_req_ff  <= 1'b1;
                            mem_we_ff   <= 1'b0;
                            mem_addr_ff <= word_addr(buf_ff, cnt_ff);
                        end
                    end
                end
                dld_pkg::ST_WBACK: begin
                    if (!mem_req_ff) begin
                        mem_req_ff  <= 1'b1;
                        mem_we_ff   <= 1'b1;
                        mem_addr_ff <= cur_addr;
                        if (chan_ff == dld_pkg::CH_RX) begin
                            mem_wdata_ff <= {1'b0, first_ff & (words_ff != 9'h000), ls_ff,
                                             18'h0_0000, cnt_ff, 2'h0};
                        end else begin
                            mem_wdata_ff <= desc0_ff & ~(32'h0000_0001 << `DLD_OWN_BIT);
                        end
                    end else if (mem_ack) begin
                        mem_req_ff <= 1'b0;
                        state_ff   <= dld_pkg::ST_IDLE;
                        if (chan_ff == dld_pkg::CH_RX) begin
                            first_ff <= ls_ff | (first_ff & (words_ff == 9'h000));
                        end
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wb_req;
        (state_ff == dld_pkg::ST_WBACK) && mem_req_ff;
    endsequence
    sequence s_rx_last_done;
        (state_ff == dld_pkg::ST_XFER) && (chan_ff == dld_pkg::CH_RX) && mem_done && last_seen_ff;
    endsequence

    property p_addr_aligned;
        mem_req_ff |-> (mem_addr_ff[1:0] == 2'h0);
    endproperty
    a_addr_aligned: assert property (p_addr_aligned) else $error("Unaligned bus address");
    property p_start_at_cur;
        (state_ff == dld_pkg::ST_IDLE && rx_en_ff && rx_valid && !rx_nodesc_ff)
            |=> mem_req_ff && !mem_we_ff && mem_addr_ff == $past(rx_cur_ff);
    endproperty
    a_start_at_cur: assert property (p_start_at_cur) else $error("Walk not at list pointer");
    property p_follow_next;
        (wb_done && chan_ff == dld_pkg::CH_RX && !apb_wr) |=> rx_cur_ff == $past(next_ff);
    endproperty
    a_follow_next: assert property (p_follow_next) else $error("Next link not followed");
    property p_desc_reads;
        (state_ff == dld_pkg::ST_DESC && mem_req_ff) |-> !mem_we_ff;
    endproperty
    a_desc_reads: assert property (p_desc_reads) else $error("Descriptor fetch not a read");
    property p_rx_buf_write;
        (state_ff == dld_pkg::ST_XFER && chan_ff == dld_pkg::CH_RX && mem_req_ff)
            |-> mem_we_ff && mem_addr_ff == buf_ff + {21'h0_0000, cnt_ff, 2'h0};
    endproperty
    a_rx_buf_write: assert property (p_rx_buf_write) else $error("Rx write off buffer");
    property p_own_released;
        s_wb_req |-> !mem_wdata_ff[`DLD_OWN_BIT] && mem_we_ff && mem_addr_ff == cur_addr;
    endproperty
    a_own_released: assert property (p_own_released) else $error("Ownership not returned");
    property p_last_closes;
        // Write-back raises its request one cycle after entering the state
        s_rx_last_done |-> ##2 s_wb_req ##0 mem_wdata_ff[`DLD_LS_BIT];
    endproperty
    a_last_closes: assert property (p_last_closes) else $error("Frame end not closed");
    property p_drop_no_write;
        (drop_ff && state_ff == dld_pkg::ST_XFER) |-> !mem_req_ff && !$past(chain_en_ff);
    endproperty
    a_drop_no_write: assert property (p_drop_no_write) else $error("Write during discard");
    property p_tx_push;
        (state_ff == dld_pkg::ST_XFER && chan_ff == dld_pkg::CH_TX && mem_done)
            |=> push_ff && push_data_ff[31:0] == $past(mem_rdata);
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("Tx word not buffered");
    property p_empty_desc;
        desc_empty |=> state_ff == dld_pkg::ST_IDLE && !mem_req_ff;
    endproperty
    a_empty_desc: assert property (p_empty_desc) else $error("Host-owned descriptor used");
endmodule

// ---- verif/dld_mem_model.sv ----
// Host memory model answering the bus-master port
`timescale 1ns/1ps
module dld_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic        slow,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    logic [2:0]  wait_ff;
    // Word aligned, low address bits ignored
    always @(posedge clk) begin
        if (mem_req && mem_ack && mem_we) mem[mem_addr[9:2]] <= mem_wdata;
    end
    always_ff @(posedge clk) begin
        if (!rst_n || !mem_req || mem_ack) begin
            mem_ack   <= 1'b0;
            wait_ff   <= slow ? 3'h5 : 3'h0;
            // Released bus toggles, never a stale word
            mem_rdata <= rst_n ? ~mem_rdata : 32'h0;
        end else if (wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
        end else begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[9:2]];
        end
    end
endmodule

// ---- verif/descriptor_list_dma_bench.sv ----
// Bench: registers, rx walks with and without chaining, tx walk
`timescale 1ns/1ps
`include "dld_params.svh"
module descriptor_list_dma_bench;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
    logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, slow;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rx_data, tx_data, rd;
    int          num_errors = 0;
    int          checks_done = 0;
    dld_desc_dma dld_desc_dma_i (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .rx_data,
        .rx_valid, .rx_last, .rx_ready, .tx_data, .tx_valid, .tx_last, .tx_ready);
    dld_mem_model dld_mem_model_i (.clk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow,
        .mem_ack, .mem_rdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Request held until pready is seen at an edge
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        check("pslverr", a > `DLD_REG_CUR, pslverr);
    endtask
    task automatic put_desc(logic [7:0] i, logic [31:0] w0, sz, bf, nx);
        dld_mem_model_i.mem[i]        = w0;
        dld_mem_model_i.mem[i + 8'h1] = sz;
        dld_mem_model_i.mem[i + 8'h2] = bf;
        dld_mem_model_i.mem[i + 8'h3] = nx;
    endtask
    // Valid stays up across the frame so no word gap appears
    task automatic rx_frame(int n, logic [31:0] d0);
        for (int k = 0; k < n; k++) begin
            rx_valid <= 1'b1;
            rx_data  <= d0 + k;
            rx_last  <= (k == n - 1);
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
    endtask
    task automatic reg_test();
        apb(1'b0, `DLD_REG_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(1'b1, `DLD_REG_RX_BASE, 32'h0000_0104);
        apb(1'b0, `DLD_REG_RX_BASE, 32'h0);
        check("rx base", 32'h0000_0104, rd);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, rd);
    endtask
    // Two-word frame into 4-byte buffers
    task automatic rx_test(logic chain);
        put_desc(8'h40, 32'h8000_0000, 32'h0000_0004, 32'h0000_0200, 32'h0000_0110);
        put_desc(8'h44, 32'h8000_0000, 32'h0000_0004, 32'h0000_0240, 32'h0000_0100);
        apb(1'b1, `DLD_REG_RX_BASE, 32'h0000_0100);
        apb(1'b1, `DLD_REG_CTRL, {29'h0, chain, 2'h1});
        rx_frame(2, {24'h0, chain, 7'h30});
        wait (dld_mem_model_i.mem[chain ? 8'h44 : 8'h40][31] === 1'b0);
        check("status a", chain ? 32'h4000_0004 : 32'h6000_0004, dld_mem_model_i.mem[8'h40]);
        check("word 0", {24'h0, chain, 7'h30}, dld_mem_model_i.mem[8'h80]);
        check("past buffer", 32'h5A5A_0081, dld_mem_model_i.mem[8'h81]);
        if (chain) begin
            check("status b", 32'h2000_0004, dld_mem_model_i.mem[8'h44]);
            check("word 1", 32'h0000_00B1, dld_mem_model_i.mem[8'h90]);
        end
        apb(1'b0, `DLD_REG_CUR, 32'h0);
        check("cur", chain ? 32'h0000_0100 : 32'h0000_0110, rd);
    endtask
    // Receiver stalls first, so the two-entry buffer fills
    task automatic tx_test();
        put_desc(8'h60, 32'hE000_0000, 32'h0000_000C, 32'h0000_0300, 32'h0000_0180);
        for (int k = 0; k < 3; k++)
            dld_mem_model_i.mem[8'hC0 + k] = 32'h0000_00C1 + k;
        slow <= 1'b0;
        apb(1'b1, `DLD_REG_TX_BASE, 32'h0000_0180);
        apb(1'b1, `DLD_REG_CTRL, 32'h0000_0002);
        repeat (30) @(posedge clk);
        tx_ready <= 1'b1;
        for (int n = 0; n < 3;) begin
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                check("tx data", 32'h0000_00C1 + n, tx_data);
                check("tx last", n == 2, tx_last);
                n++;
            end
        end
        wait (dld_mem_model_i.mem[8'h60][31] === 1'b0);
        check("tx status", 32'h6000_0000, dld_mem_model_i.mem[8'h60]);
        rd = '0;
        for (int k = 0; k < 20 && rd[`DLD_ST_TX_NODESC] !== 1'b1; k++)
            apb(1'b0, `DLD_REG_STATUS, 32'h0);
        check("tx nodesc", 32'h1, rd[`DLD_ST_TX_NODESC]);
        apb(1'b1, `DLD_REG_CTRL, 32'h0000_0000);
        apb(1'b1, `DLD_REG_STATUS, 32'h0000_0001 << `DLD_ST_TX_NODESC);
        apb(1'b0, `DLD_REG_STATUS, 32'h0);
        check("status after clear", 32'h0000_0001 << `DLD_ST_CHAN, rd);
    endtask
    initial begin
        {psel, penable, pwrite, rx_valid, rx_last, tx_ready, slow} = '0;
        {paddr, pwdata, rx_data} = '0;
        rst_n = 1'b0;
        for (int i = 0; i < 256; i++)
            dld_mem_model_i.mem[i] = 32'h5A5A_0000 + i;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_test();
        rx_test(1'b0);
        slow <= 1'b1;
        rx_test(1'b1);
        tx_test();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
